// File: core/sd_readout_params.svh
// Purpose: Named constants for the sigma-delta word readout block
// Assumes: 200 MHz system clock
// Notes: Times kept in their own unit, cycle counts derived
`ifndef SD_READOUT_PARAMS_SVH
`define SD_READOUT_PARAMS_SVH
`define CLK_MHZ 200
`define WORD_BITS 16
`define MCLK_DIV 25
`define WORD_RATE_HZ 4000
`define WORD_PERIOD_CYC ((`CLK_MHZ * 1000000) / `WORD_RATE_HZ)
`define SEL_BLANK_MCLK 4
`define SEL_EXTRA_NS 160
`define SEL_EXTRA_CYC ((`SEL_EXTRA_NS * `CLK_MHZ + 999) / 1000)
`define CAL_STEP_CYC 64
`define MID_CODE 16'h8000
`define ONES_CODE 16'hFFFF
`endif

// File: core/sd_readout_pkg.sv
// Purpose: Types for the sigma-delta word readout block
// Assumes: Included parameter header
// Notes: Calibration phases
package sd_readout_pkg;
  typedef enum logic [1:0] {CAL_IDLE, CAL_ZERO, CAL_FULL} cal_state_e;
  typedef logic [15:0] word_t;
endpackage

// File: core/sd_word_readout.sv
// Purpose: Output word register, calibration and serial shift-out
// Assumes: Shift clock and select come from the host in their own domain
// Notes: Conversion sample arrives as a raw signed value from the filter
// Contract
// - Select released mid-word: finish current bit, then float data and clock.
// - Each new data bit appears on the falling shift clock edge.
// - Select ignored while word-ready high; recognition lags up to four clocks plus 160 ns.
// - Filter refreshes the 16-bit word at 4 kHz; host reads up to that rate.
// - Calibrate input starts a calibration cycle at any time; results held internally.
// - Calibration mode select low means offset reference taken from input pin.
// - System calibration takes zero-scale then full-scale points to set range; the span scales unipolar output only, bipolar ignores it.
// - Bipolar output is offset binary, midscale between 7FFF and 8000.
// - Unipolar output is straight binary from all zeros to all ones.
// - Conversion runs continuously; word always available without a start command.
`timescale 1ns/1ps
`include "sd_readout_params.svh"
module sd_word_readout #(
  parameter int WORD_PERIOD = `WORD_PERIOD_CYC,
  parameter int CAL_STEP = `CAL_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic signed [16:0] sample_i,
  input wire logic bipolar_i,
  input wire logic calibrate_i,
  input wire logic calib_mode_select_b_i,
  input wire logic sclk_i,
  input wire logic sel_n_i,
  output sd_readout_pkg::word_t data_word_o,
  output logic word_ready_n_o,
  output logic cal_busy_o,
  output logic serial_out_line_o,
  output logic serial_out_line_oe_o,
  output logic sclk_oe_o
);
  import sd_readout_pkg::*;

  // The word-ready low window must outlast the select recognition delay
  if (WORD_PERIOD < 2 * (`SEL_BLANK_MCLK * `MCLK_DIV + `SEL_EXTRA_CYC) || CAL_STEP < 1) begin : g_bad
    $error("sd_word_readout: unsupported parameter");
  end

  // Clamp a wide signed result into the 16-bit code range
  function automatic word_t sat16(input logic signed [34:0] v);
    if (v > 35'sd65535) begin
      sat16 = `ONES_CODE;
    end else if (v < 35'sd0) begin
      sat16 = 16'h0000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // Input synchronisers
  logic [1:0] cal_sync_q, cal_sync_d;
  logic [1:0] sel_sync_q, sel_sync_d;
  logic [1:0] done_sync_q, done_sync_d;
  logic cal_prev_q, cal_prev_d;
  logic [1:0] msel_sync_q, msel_sync_d;

  // Link domain state, declared here because the system side reads its toggle
  logic [2:0] go_sync_q, go_sync_d;
  logic [1:0] lsel_q, lsel_d;
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic [15:0] sh_q, sh_d;
  logic act_q, act_d;
  logic done_tog_q, done_tog_d;
  logic sdo_q, sdo_d;
  logic oe_q, oe_d;

  // Conversion and calibration state
  logic [31:0] rate_cnt_q, rate_cnt_d;
  word_t word_q, word_d;
  logic signed [16:0] offset_q, offset_d;
  logic signed [16:0] span_q, span_d;
  cal_state_e cal_q, cal_d;
  logic [15:0] cal_cnt_q, cal_cnt_d;
  logic [7:0] rdy_cnt_q, rdy_cnt_d;
  logic rdy_n_q, rdy_n_d;
  logic [7:0] sel_cnt_q, sel_cnt_d;
  logic go_tog_q, go_tog_d;
  word_t shadow_q, shadow_d;
  logic [4:0] mclk_q, mclk_d;

  always_comb begin
    cal_sync_d = {cal_sync_q[0], calibrate_i};
    sel_sync_d = {sel_sync_q[0], sel_n_i};
    done_sync_d = {done_sync_q[0], done_tog_q};
    cal_prev_d = cal_sync_q[1];
    msel_sync_d = {msel_sync_q[0], calib_mode_select_b_i};
    rate_cnt_d = rate_cnt_q;
    word_d = word_q;
    offset_d = offset_q;
    span_d = span_q;
    cal_d = cal_q;
    cal_cnt_d = cal_cnt_q;
    rdy_cnt_d = rdy_cnt_q;
    rdy_n_d = rdy_n_q;
    sel_cnt_d = sel_cnt_q;
    go_tog_d = go_tog_q;
    shadow_d = shadow_q;
    mclk_d = (mclk_q == 5'(`MCLK_DIV - 1)) ? 5'h00 : mclk_q + 5'h01;
    // Free-running conversion, one word per period while calibration is idle
    if (rate_cnt_q >= 32'(WORD_PERIOD - 1)) begin
      rate_cnt_d = 32'h0;
      if (cal_q == CAL_IDLE) begin
        if (bipolar_i) begin
          // Offset binary: zero input maps to 8000
          word_d = sat16(35'(sample_i) - 35'(offset_q) + 35'(`MID_CODE));
        end else begin
          // Straight binary, clamped to 0000..FFFF
          // Product kept at full width so the gain cannot wrap
          word_d = sat16((35'(sample_i) - 35'(offset_q)) * 35'sd65535 / 35'(span_q));
        end
        // Word-ready blank window before each update
        rdy_n_d = 1'b0;
      end
    end else begin
      rate_cnt_d = rate_cnt_q + 32'h1;
    end
    if (rate_cnt_q == 32'(WORD_PERIOD - 1 - `SEL_BLANK_MCLK * `MCLK_DIV)) begin
      rdy_n_d = 1'b1;
    end
    // Calibration starts on any rising request
    if (cal_sync_q[1] && !cal_prev_q) begin
      cal_d = CAL_ZERO;
      cal_cnt_d = 16'h0;
    end else if (cal_q != CAL_IDLE) begin
      cal_cnt_d = cal_cnt_q + 16'h1;
      if (cal_cnt_q == 16'(CAL_STEP - 1)) begin
        cal_cnt_d = 16'h0;
        if (cal_q == CAL_ZERO) begin
          // Offset from input pin or internal ground
          offset_d = msel_sync_q[1] ? 17'sd0 : sample_i;
          cal_d = CAL_FULL;
        end else begin
          // Span from full-scale point minus zero point
          span_d = (sample_i - offset_q > 17'sd0) ? sample_i - offset_q : 17'sd65535;
          cal_d = CAL_IDLE;
        end
      end
    end
    // Select recognised after blank clocks plus 160 ns
    if (sel_sync_q[1] || rdy_n_q) begin
      sel_cnt_d = 8'h0;
    end else if (sel_cnt_q < 8'(`SEL_BLANK_MCLK * `MCLK_DIV + `SEL_EXTRA_CYC)) begin
      sel_cnt_d = sel_cnt_q + 8'h1;
      if (sel_cnt_q == 8'(`SEL_BLANK_MCLK * `MCLK_DIV + `SEL_EXTRA_CYC - 1)) begin
        shadow_d = word_q;
        go_tog_d = ~go_tog_q;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cal_sync_q <= 2'b00;
      sel_sync_q <= 2'b11;
      done_sync_q <= 2'b00;
      cal_prev_q <= 1'b0;
      msel_sync_q <= 2'b11;
      rate_cnt_q <= 32'h0;
      word_q <= `MID_CODE;
      offset_q <= 17'sd0;
      span_q <= 17'sd65535;
      cal_q <= CAL_IDLE;
      cal_cnt_q <= 16'h0;
      rdy_n_q <= 1'b1;
      rdy_cnt_q <= 8'h0;
      sel_cnt_q <= 8'h0;
      go_tog_q <= 1'b0;
      shadow_q <= 16'h0000;
      mclk_q <= 5'h00;
    end else if (en_i) begin
      cal_sync_q <= cal_sync_d;
      sel_sync_q <= sel_sync_d;
      done_sync_q <= done_sync_d;
      cal_prev_q <= cal_prev_d;
      msel_sync_q <= msel_sync_d;
      rate_cnt_q <= rate_cnt_d;
      word_q <= word_d;
      offset_q <= offset_d;
      span_q <= span_d;
      cal_q <= cal_d;
      cal_cnt_q <= cal_cnt_d;
      rdy_n_q <= rdy_n_d;
      rdy_cnt_q <= rdy_cnt_d;
      sel_cnt_q <= sel_cnt_d;
      go_tog_q <= go_tog_d;
      shadow_q <= shadow_d;
      mclk_q <= mclk_d;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_word_o <= `MID_CODE;
      word_ready_n_o <= 1'b1;
      cal_busy_o <= 1'b0;
    end else if (en_i) begin
      data_word_o <= word_q;
      word_ready_n_o <= rdy_n_q;
      cal_busy_o <= (cal_q != CAL_IDLE);
    end
  end

  // Link domain on the host shift clock
  always_comb begin
    go_sync_d = {go_sync_q[1:0], go_tog_q};
    lsel_d = {lsel_q[0], sel_n_i};
    bit_cnt_d = bit_cnt_q;
    sh_d = sh_q;
    act_d = act_q;
    done_tog_d = done_tog_q;
    sdo_d = sdo_q;
    oe_d = oe_q;
    if (go_sync_q[2] != go_sync_q[1]) begin
      // Word latched; MSB driven until first falling edge
      sh_d = shadow_q;
      sdo_d = shadow_q[15];
      bit_cnt_d = 5'h0;
      act_d = 1'b1;
      oe_d = 1'b1;
    end else if (act_q) begin
      // Next bit on falling shift clock
      bit_cnt_d = bit_cnt_q + 5'h1;
      sh_d = {sh_q[14:0], 1'b0};
      sdo_d = sh_q[14];
      // Release ends after current bit completes
      if (lsel_q[1] || bit_cnt_q == 5'(`WORD_BITS - 1)) begin
        act_d = 1'b0;
        oe_d = 1'b0;
        done_tog_d = ~done_tog_q;
      end
    end
  end

  always_ff @(negedge sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      go_sync_q <= 3'b000;
      lsel_q <= 2'b11;
      bit_cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      act_q <= 1'b0;
      done_tog_q <= 1'b0;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      go_sync_q <= go_sync_d;
      lsel_q <= lsel_d;
      bit_cnt_q <= bit_cnt_d;
      sh_q <= sh_d;
      act_q <= act_d;
      done_tog_q <= done_tog_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
    end
  end

  assign serial_out_line_o = sdo_q;
  assign serial_out_line_oe_o = oe_q;
  assign sclk_oe_o = oe_q;
endmodule

// File: dv/sd_word_readout_chk.sv
// Purpose: Port assertions for the word readout
// Assumes: Bound to the readout block
// Notes: System clock domain only
`timescale 1ns/1ps
module sd_word_readout_chk (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic calibrate_i,
  input wire logic sel_n_i,
  input wire logic sclk_i,
  input wire sd_readout_pkg::word_t data_word_o,
  input wire logic word_ready_n_o,
  input wire logic cal_busy_o,
  input wire logic serial_out_line_o,
  input wire logic serial_out_line_oe_o,
  input wire logic sclk_oe_o
);
  import sd_readout_pkg::*;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  oe_pair_a: assert property (sclk_oe_o == serial_out_line_oe_o)
    else $error("enables differ");
  oe_off_a: assert property ($rose(sel_n_i) |-> ##[0:30] !serial_out_line_oe_o)
    else $error("line not released");
  oe_sel_a: assert property ($rose(serial_out_line_oe_o) |-> !sel_n_i)
    else $error("driving without select");
  bit_edge_a: assert property ($changed(serial_out_line_o) |-> !sclk_i)
    else $error("bit changed off falling edge");
  word_hold_a: assert property ($changed(data_word_o) |-> $past(word_ready_n_o))
    else $error("word changed while fresh");
  ready_len_a: assert property ($rose(word_ready_n_o) |-> word_ready_n_o[*8])
    else $error("ready pulse short");
  ready_end_a: assert property ($rose(word_ready_n_o) |-> ##[90:110] !word_ready_n_o)
    else $error("ready pulse long");
  cal_start_a: assert property ($rose(calibrate_i) |-> ##[1:6] cal_busy_o)
    else $error("calibration not started");
  cover property ($rose(serial_out_line_oe_o));
  cover property ($fell(cal_busy_o));
  cover property ($rose(word_ready_n_o));
endmodule
bind sd_word_readout sd_word_readout_chk chk (.clk_i(clk_i), .nrst_i(nrst_i),
  .calibrate_i(calibrate_i), .sel_n_i(sel_n_i), .sclk_i(sclk_i), .data_word_o(data_word_o),
  .word_ready_n_o(word_ready_n_o), .cal_busy_o(cal_busy_o),
  .serial_out_line_o(serial_out_line_o), .serial_out_line_oe_o(serial_out_line_oe_o),
  .sclk_oe_o(sclk_oe_o));

// File: dv/sd_host_model.sv
// Purpose: Host serial port driving select and shift clock
// Assumes: Shift clock period 15 ns, idle low between frames
// Notes: A released data line reads back as a toggling value
`timescale 1ns/1ps
module sd_host_model (
  input wire logic data_i,
  input wire logic oe_i,
  output logic sclk_o,
  output logic sel_n_o
);
  logic last_q = 1'b0;
  wire logic line = oe_i ? data_i : ~last_q;
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
  end
  always @(posedge sclk_o) begin
    last_q <= line;
  end
  task automatic cyc();
    #7.5 sclk_o = 1'b1;
    #7.5 sclk_o = 1'b0;
  endtask
  task automatic read(input int n, output logic [15:0] w, output int got);
    w = 16'h0000;
    got = 0;
    sel_n_o = 1'b0;
    #700; // Shift clock held low after select
    for (int k = 0; k < 3000 && got < n; k++) begin
      #7.5 sclk_o = 1'b1;
      if (oe_i) begin
        w = {w[14:0], line};
        got++;
      end
      #7.5 sclk_o = 1'b0;
    end
    sel_n_o = 1'b1;
    repeat (10) cyc();
  endtask
endmodule

// File: dv/test_sd_word_readout.sv
// Purpose: Self-checking bench for the word readout
// Assumes: Short word period and calibration step
// Notes: Host model reads words over the serial link
`timescale 1ns/1ps
module test_sd_word_readout;
  import sd_readout_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic bipolar_i = 1'b1;
  logic calibrate_i = 1'b0;
  logic calib_mode_select_b_i = 1'b1;
  logic signed [16:0] sample_i = 17'sh00000;
  logic sclk, sel_n, dout, doe, ready_n, busy;
  word_t word;
  logic [15:0] w;
  int got;
  int bad_count = 0;
  int checks = 0;
  int tick = 0;
  sd_word_readout #(.WORD_PERIOD(400), .CAL_STEP(40)) DUT (.clk_i(clk_i), .nrst_i(nrst_i),
    .en_i(1'b1), .sample_i(sample_i), .bipolar_i(bipolar_i), .calibrate_i(calibrate_i),
    .calib_mode_select_b_i(calib_mode_select_b_i), .sclk_i(sclk), .sel_n_i(sel_n),
    .data_word_o(word), .word_ready_n_o(ready_n), .cal_busy_o(busy),
    .serial_out_line_o(dout), .serial_out_line_oe_o(doe), .sclk_oe_o());
  sd_host_model host (.data_i(dout), .oe_i(doe), .sclk_o(sclk), .sel_n_o(sel_n));
  initial begin
    forever #2.5 clk_i = ~clk_i; // Master clock never stops
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic fresh(input logic bip, input logic signed [16:0] s);
    @(posedge clk_i);
    bipolar_i <= bip;
    sample_i <= s;
    repeat (2) @(negedge ready_n);
    @(posedge clk_i);
  endtask
  task automatic t_codes();
    logic [5:0] bip = 6'b111100;
    int smp[6] = '{0, -1, 32767, -32768, 0, 1234};
    logic [15:0] exp[6] = '{16'h8000, 16'h7FFF, 16'hFFFF, 16'h0000, 16'h0000, 16'h04D2};
    for (int i = 0; i < 6; i++) begin
      fresh(bip[5 - i], 17'(smp[i]));
      check("word", word, exp[i]);
    end
    $display("codes test done");
  endtask
  task automatic t_serial();
    fresh(1'b1, -17'sd1);
    repeat (2) begin
      host.read(16, w, got);
      check("serial word", w, 16'h7FFF);
    end
    fresh(1'b1, 17'sh00234);
    host.read(5, w, got);
    check("partial bits", w, 16'h0010);
    check("released", {15'h0000, doe}, 16'h0000);
    $display("serial test done");
  endtask
  task automatic t_cal();
    for (int m = 0; m < 2; m++) begin
      @(negedge ready_n);
      @(posedge clk_i);
      calib_mode_select_b_i <= m[0];
      sample_i <= 17'sh00100; // Zero-scale point first
      calibrate_i <= 1'b1;
      for (int k = 0; k < 50 && busy !== 1'b1; k++) @(posedge clk_i);
      check("busy", {15'h0000, busy}, 16'h0001);
      calibrate_i <= 1'b0;
      repeat (60) @(posedge clk_i);
      sample_i <= 17'sh07FFF; // Full-scale point second
      for (int k = 0; k < 20000 && busy !== 1'b0; k++) @(posedge clk_i);
      check("idle", {15'h0000, busy}, 16'h0000);
      fresh(1'b0, 17'sh00100);
      check("cal word", word, m[0] ? 16'h0200 : 16'h0000);
    end
    $display("calibration test done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    tick++;
    if (tick == 80000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    repeat (3) host.cyc();
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("reset word", word, 16'h8000);
    t_codes();
    t_serial();
    t_cal();
    results();
  end
endmodule
